//--- src/igb_pkg.sv
// Constants and carrier types for the interrupt gating bank.
// Assumes a 32-bit APB slave with a 12-bit byte address.
package igb_pkg;

	// Each function is a pair of words; word two sits four bytes above one
	localparam logic [11:0] ENABLE_ONE_OFS = 12'h010;
	localparam logic [11:0] ENABLE_TWO_OFS = 12'h014;
	localparam logic [11:0] PENDING_ONE_OFS = 12'h020;
	localparam logic [11:0] PENDING_TWO_OFS = 12'h024;
	localparam logic [11:0] REQUEST_ONE_OFS = 12'h030;
	localparam logic [11:0] REQUEST_TWO_OFS = 12'h034;
	localparam logic [11:0] ARM_ONE_OFS = 12'h040;
	localparam logic [11:0] ARM_TWO_OFS = 12'h044;
	localparam logic [11:0] MODE_ONE_OFS = 12'h050;
	localparam logic [11:0] MODE_TWO_OFS = 12'h054;
	localparam logic [11:0] POLARITY_ONE_OFS = 12'h060;
	localparam logic [11:0] POLARITY_TWO_OFS = 12'h064;

	// Clear shares the pending offsets on the write side
	localparam logic [11:0] CLEAR_ONE_OFS = PENDING_ONE_OFS;
	localparam logic [11:0] CLEAR_TWO_OFS = PENDING_TWO_OFS;

	// Bits that carry a source in each word
	localparam logic [31:0] SOURCE_MASK_ONE = 32'hFFF0FFFF;
	localparam logic [31:0] SOURCE_MASK_TWO = 32'h0F000F00;

	// Field positions within word one
	localparam int TIMER_LSB = 0;
	localparam int EXT_LSB = 8;
	localparam int AUX_LSB = 20;
	localparam int GROUP_C_LSB = 24;
	// Field positions within word two (upper source numbers)
	localparam int EXT_HI_LSB = 8;
	localparam int GROUP_C_HI_LSB = 24;

	// Word-one position of the "word two has nothing pending" flag
	localparam int SUMMARY_BIT = 16;

	// Reset values of the control words
	localparam logic [31:0] ENABLE_RESET = 32'h00000000;
	localparam logic [31:0] ARM_RESET = 32'h00000000;
	localparam logic [31:0] MODE_RESET = 32'h00000000;
	localparam logic [31:0] POLARITY_RESET = 32'h00000000;

	localparam logic [31:0] READ_ZERO = 32'h00000000;

	typedef struct packed {
		logic [31:0] two;
		logic [31:0] one;
	} irq_pair_t;

	typedef struct packed {
		irq_pair_t enable;
		irq_pair_t arm;
		irq_pair_t mode;
		irq_pair_t polarity;
	} ctl_t;

endpackage

//--- src/source_cell.sv
// One interrupt source: polarity, level/edge sensing, arming and pending.
// Assumes the source input is synchronous to pclk.
`timescale 1ns/1ps
module source_cell
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Source and configuration
	input wire logic source_in,
	input wire logic level_mode,
	input wire logic active_high,
	input wire logic armed,
	// Software strobes, one cycle each
	input wire logic sw_request,
	input wire logic sw_clear,
	// State
	output logic pending
);

	logic asserted;
	logic prev_q;
	logic prev_d;
	logic held_q;
	logic held_d;
	logic edge_seen;
	logic set_held;

	// Polarity folds both senses into one active-high view
	assign asserted = active_high ? source_in : ~source_in;
	assign edge_seen = asserted & ~prev_q;

	always_comb
	begin
		prev_d = asserted;
		// Request behaves as an assertion: edge mode still needs the arm
		if (level_mode)
			set_held = sw_request;
		else
			set_held = armed & (edge_seen | sw_request);
		// Set wins over a clear arriving in the same cycle
		if (set_held)
			held_d = 1'b1;
		else if (sw_clear)
			held_d = 1'b0;
		else
			held_d = held_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_q <= 1'b0;
			held_q <= 1'b0;
		end
		else
		begin
			prev_q <= prev_d;
			held_q <= held_d;
		end
	end

	// Level sources follow the input; a held software request adds to it
	assign pending = level_mode ? (asserted | held_q) : held_q;

endmodule

//--- src/interrupt_gating_bank.sv
// Interrupt gating bank: APB register file, per-source sensing cells,
// and the combined request toward the host.
// Assumes a zero-wait APB master and sources synchronous to pclk.
`timescale 1ns/1ps

// What this block does
// - A source reaches the host request only while its enable bit is set.
// - A request-register write acts like a hardware edge in edge mode, and latches until cleared in level mode.
// - Pending words show each registered, not yet removed request.
// - Clear writes remove latched pending for set bits and leave zero bits alone; a level source stays pending while asserted.
// - Edge sources capture edges only while their arm bit is set.
// - Mode bit 1 selects level sensing, 0 selects edge sensing.
// - Polarity bit 1 means high or rising, 0 means low or falling.
// - Functions are word pairs at 0x10 through 0x64, pending at 0x20/0x24.
// - Pending word one bit 16 reads 1 when word two has nothing pending.
// - Except pending word one bit 16 and the mode and polarity selects, a control or status bit of 1 means on, 0 means off.
module interrupt_gating_bank
	import igb_pkg::*;
(
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// APB answer
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt sources
	input wire logic [7:0] timer_sources,
	input wire logic [11:0] external_sources,
	input wire logic [3:0] aux_sources,
	input wire logic [11:0] group_c_lines,
	// Combined request to the host
	output logic irq_req
);

	ctl_t ctl_q;
	ctl_t ctl_d;
	irq_pair_t src;
	irq_pair_t pend;
	irq_pair_t req_strobe;
	irq_pair_t clr_strobe;
	irq_pair_t valid;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic irq_q;
	logic irq_d;
	logic setup;
	logic access;
	logic mapped;
	logic wr;
	logic no_pending_two;
	logic [31:0] rd_data;
	irq_pair_t wmask;
	irq_pair_t gated;

	// Same map as valid, fixed at elaboration for the cell loop
	localparam logic [63:0] CELLS = {SOURCE_MASK_TWO, SOURCE_MASK_ONE};

	assign valid.one = SOURCE_MASK_ONE;
	assign valid.two = SOURCE_MASK_TWO;

	// Empty positions are dropped before anything stores or strobes
	assign wmask.one = pwdata & valid.one;
	assign wmask.two = pwdata & valid.two;

	// Source placement in the two words
	always_comb
	begin
		src = '0;
		src.one[TIMER_LSB +: 8] = timer_sources;
		src.one[EXT_LSB +: 8] = external_sources[7:0];
		src.one[AUX_LSB +: 4] = aux_sources;
		src.one[GROUP_C_LSB +: 8] = group_c_lines[7:0];
		src.two[EXT_HI_LSB +: 4] = external_sources[11:8];
		src.two[GROUP_C_HI_LSB +: 4] = group_c_lines[11:8];
	end

	// APB phases and decode
	assign setup = psel & ~penable;
	assign access = psel & penable;

	always_comb
	begin
		unique case (paddr)
			ENABLE_ONE_OFS,
			ENABLE_TWO_OFS,
			PENDING_ONE_OFS,
			PENDING_TWO_OFS,
			REQUEST_ONE_OFS,
			REQUEST_TWO_OFS,
			ARM_ONE_OFS,
			ARM_TWO_OFS,
			MODE_ONE_OFS,
			MODE_TWO_OFS,
			POLARITY_ONE_OFS,
			POLARITY_TWO_OFS:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end

	// Zero wait: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign wr = access & pwrite & mapped;

	// Control words; unused bit positions never store
	always_comb
	begin
		ctl_d = ctl_q;
		if (wr)
		begin
			unique case (paddr)
				ENABLE_ONE_OFS:
					ctl_d.enable.one = pwdata & valid.one;
				ENABLE_TWO_OFS:
					ctl_d.enable.two = pwdata & valid.two;
				ARM_ONE_OFS:
					ctl_d.arm.one = pwdata & valid.one;
				ARM_TWO_OFS:
					ctl_d.arm.two = pwdata & valid.two;
				MODE_ONE_OFS:
					ctl_d.mode.one = pwdata & valid.one;
				MODE_TWO_OFS:
					ctl_d.mode.two = pwdata & valid.two;
				POLARITY_ONE_OFS:
					ctl_d.polarity.one = pwdata & valid.one;
				POLARITY_TWO_OFS:
					ctl_d.polarity.two = pwdata & valid.two;
				// Pending and request words act through strobes only
				PENDING_ONE_OFS,
				PENDING_TWO_OFS,
				REQUEST_ONE_OFS,
				REQUEST_TWO_OFS:
					ctl_d = ctl_q;
				default:
					ctl_d = ctl_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_q.enable.one <= ENABLE_RESET;
			ctl_q.enable.two <= ENABLE_RESET;
			ctl_q.arm.one <= ARM_RESET;
			ctl_q.arm.two <= ARM_RESET;
			ctl_q.mode.one <= MODE_RESET;
			ctl_q.mode.two <= MODE_RESET;
			ctl_q.polarity.one <= POLARITY_RESET;
			ctl_q.polarity.two <= POLARITY_RESET;
		end
		else
		begin
			ctl_q <= ctl_d;
		end
	end

	// One-cycle strobes for the write-only request and clear words
	always_comb
	begin
		req_strobe = '0;
		clr_strobe = '0;
		if (wr)
		begin
			unique case (paddr)
				REQUEST_ONE_OFS:
					req_strobe.one = wmask.one;
				REQUEST_TWO_OFS:
					req_strobe.two = wmask.two;
				CLEAR_ONE_OFS:
					clr_strobe.one = wmask.one;
				CLEAR_TWO_OFS:
					clr_strobe.two = wmask.two;
				default:
				begin
					req_strobe = '0;
					clr_strobe = '0;
				end
			endcase
		end
	end

	// One cell per populated bit position of both words
	genvar i;
	generate
		for (i = 0; i < 64; i++)
		begin : g_src
			// Empty positions get no cell and can never pend
			if (CELLS[i])
			begin : g_cell
				source_cell u_cell
				(
					.pclk(pclk),
					.presetn(presetn),
					.source_in(src[i]),
					.level_mode(ctl_q.mode[i]),
					.active_high(ctl_q.polarity[i]),
					.armed(ctl_q.arm[i]),
					.sw_request(req_strobe[i]),
					.sw_clear(clr_strobe[i]),
					.pending(pend[i])
				);
			end
			else
			begin : g_none
				assign pend[i] = 1'b0;
			end
		end
	endgenerate

	assign no_pending_two = ~|pend.two;

	// Pending shows regardless of enable; only the request is gated
	assign gated.one = pend.one & ctl_q.enable.one;
	assign gated.two = pend.two & ctl_q.enable.two;

	// Read mux; write-only words read as zero
	always_comb
	begin
		unique case (paddr)
			ENABLE_ONE_OFS:
				rd_data = ctl_q.enable.one;
			ENABLE_TWO_OFS:
				rd_data = ctl_q.enable.two;
			PENDING_ONE_OFS:
			begin
				rd_data = pend.one;
				rd_data[SUMMARY_BIT] = no_pending_two;
			end
			PENDING_TWO_OFS:
				rd_data = pend.two;
			REQUEST_ONE_OFS,
			REQUEST_TWO_OFS:
				rd_data = READ_ZERO;
			ARM_ONE_OFS:
				rd_data = ctl_q.arm.one;
			ARM_TWO_OFS:
				rd_data = ctl_q.arm.two;
			MODE_ONE_OFS:
				rd_data = ctl_q.mode.one;
			MODE_TWO_OFS:
				rd_data = ctl_q.mode.two;
			POLARITY_ONE_OFS:
				rd_data = ctl_q.polarity.one;
			POLARITY_TWO_OFS:
				rd_data = ctl_q.polarity.two;
			default:
				rd_data = READ_ZERO;
		endcase
	end

	// Read data is caught in setup so the access phase sees a flop output
	always_comb
	begin
		prdata_d = prdata_q;
		if (setup)
		begin
			if (pwrite)
				prdata_d = READ_ZERO;
			else
				prdata_d = rd_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= READ_ZERO;
		end
		else
		begin
			prdata_q <= prdata_d;
		end
	end

	// Registered, so decode hazards never reach the host line
	always_comb
	begin
		irq_d = |gated;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= irq_d;
		end
	end

	assign prdata = prdata_q;
	assign irq_req = irq_q;

endmodule

//--- testbench/host_model.sv
// Host side model: counts each new request it must service.
// Sees only the combined request line of the block.
`timescale 1ns/1ps
module host_model
(
	// Clock, reset, request
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq_req,
	// Requests seen
	output int irq_seen
);
	logic irq_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_q <= 1'b0;
			irq_seen <= 0;
		end
		else
		begin
			irq_q <= irq_req;
			if (irq_req && !irq_q)
				irq_seen <= irq_seen + 1;
		end
	end
endmodule

//--- testbench/igb_chk.sv
// Port checker for the interrupt gating bank.
// Bound to the top module; shadows the enable words only.
`timescale 1ns/1ps
module igb_chk
	import igb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Host request
	input wire logic irq_req
);
	logic [31:0] en1_q, en1_d, en2_q, en2_d;
	logic hit, wr, en_any;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign hit = paddr[11:7] == 5'h00 && paddr[3] == 1'b0 &&
		paddr[1:0] == 2'h0 && paddr[6:4] != 3'h0 && paddr[6:4] != 3'h7;
	assign wr = psel && penable && pwrite;
	assign en_any = |(en1_q | en2_q);
	always_comb
	begin
		en1_d = en1_q;
		en2_d = en2_q;
		if (wr && paddr == ENABLE_ONE_OFS)
			en1_d = pwdata & SOURCE_MASK_ONE;
		if (wr && paddr == ENABLE_TWO_OFS)
			en2_d = pwdata & SOURCE_MASK_TWO;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en1_q <= ENABLE_RESET;
			en2_q <= ENABLE_RESET;
		end
		else
		begin
			en1_q <= en1_d;
			en2_q <= en2_d;
		end
	end
	sequence s_setup; psel && !penable && !pwrite; endsequence
	sequence s_rd(a); s_setup ##0 paddr == a; endsequence
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err; psel && penable |-> pslverr == !hit; endproperty
	a_err: assert property (p_err) else $error("pslverr wrong");
	property p_miss; s_setup ##0 !hit |=> prdata == READ_ZERO; endproperty
	a_miss: assert property (p_miss) else $error("unmapped read");
	property p_req; s_rd(REQUEST_TWO_OFS) |=> prdata == READ_ZERO; endproperty
	a_req: assert property (p_req) else $error("request read");
	property p_en1; s_rd(ENABLE_ONE_OFS) |=> prdata == en1_q; endproperty
	a_en1: assert property (p_en1) else $error("enable one");
	property p_en2; s_rd(ENABLE_TWO_OFS) |=> prdata == en2_q; endproperty
	a_en2: assert property (p_en2) else $error("enable two");
	property p_irq; irq_req |-> $past(en_any); endproperty
	a_irq: assert property (p_irq) else $error("irq unmasked");
	property p_hold; !psel || penable |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold) else $error("prdata moved");
endmodule

bind interrupt_gating_bank igb_chk chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_req);

//--- testbench/interrupt_gating_bank_tb.sv
// Testbench: APB master tasks and one task per scenario.
// Host model counts requests; sources are driven here.
`timescale 1ns/1ps
module interrupt_gating_bank_tb
	import igb_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, slv, irq_req;
	logic [7:0] timer_sources = 8'h00;
	logic [11:0] external_sources = 12'h000;
	logic [3:0] aux_sources = 4'h0;
	logic [11:0] group_c_lines = 12'h000;
	int error_cnt = 0;
	int checked = 0;
	int irq_seen, n;
	interrupt_gating_bank dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .timer_sources,
		.external_sources, .aux_sources, .group_c_lines, .irq_req);
	host_model host (.pclk, .presetn, .irq_req, .irq_seen);
	initial
	begin
		forever #4 pclk = ~pclk;
	end
	task summarize;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1)
		begin
			chk(1'b0, "timeout");
			disable scen;
		end
		rdat = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input string m);
		xfer(1'b0, a, 32'h0);
		chk(rdat === e, m);
	endtask
	// Look at irq mid-cycle, away from the edge that updates it
	task irq_is(input logic e, input string m);
		@(negedge pclk);
		chk(irq_req === e, m);
		@(posedge pclk);
	endtask
	task t_reset;
		rd(ENABLE_ONE_OFS, ENABLE_RESET, "enable reset");
		rd(MODE_TWO_OFS, MODE_RESET, "mode reset");
		rd(PENDING_ONE_OFS, 32'h00010000, "summary set");
		rd(PENDING_TWO_OFS, 32'h0, "pending two");
		irq_is(1'b0, "irq reset");
		$display("t_reset done");
	endtask
	task t_map;
		int b[4] = '{1, 4, 5, 6};
		logic [11:0] a;
		for (int i = 0; i < 8; i++)
		begin
			a = 12'(b[i / 2] * 16 + i % 2 * 4);
			wr(a, 32'hFFFFFFFF);
			rd(a, i % 2 ? SOURCE_MASK_TWO : SOURCE_MASK_ONE, "mask");
			wr(a, 32'h0);
		end
		rd(REQUEST_TWO_OFS, 32'h0, "request reads 0");
		wr(12'h008, 32'h1);
		chk(slv === 1'b1, "slverr");
		rd(12'h008, 32'h0, "unmapped");
		$display("t_map done");
	endtask
	task t_level;
		wr(MODE_ONE_OFS, 32'h00100000);
		wr(POLARITY_ONE_OFS, 32'h00100000);
		wr(ENABLE_ONE_OFS, 32'h00100000);
		aux_sources <= 4'h1;
		rd(PENDING_ONE_OFS, 32'h00110000, "level high");
		irq_is(1'b1, "level irq");
		wr(ENABLE_ONE_OFS, 32'h0);
		irq_is(1'b0, "masked");
		aux_sources <= 4'h0;
		rd(PENDING_ONE_OFS, 32'h00010000, "level follows");
		wr(POLARITY_ONE_OFS, 32'h0);
		rd(PENDING_ONE_OFS, 32'h00110000, "active low");
		wr(MODE_ONE_OFS, 32'h0);
		rd(PENDING_ONE_OFS, 32'h00010000, "edge unarmed");
		$display("t_level done");
	endtask
	task t_sw;
		wr(REQUEST_ONE_OFS, 32'h2);
		rd(PENDING_ONE_OFS, 32'h00010000, "unarmed req");
		wr(ARM_ONE_OFS, 32'h2);
		wr(REQUEST_ONE_OFS, 32'h2);
		rd(PENDING_ONE_OFS, 32'h00010002, "request");
		wr(CLEAR_ONE_OFS, 32'h2);
		rd(PENDING_ONE_OFS, 32'h00010000, "cleared");
		timer_sources <= 8'h02;
		@(posedge pclk);
		timer_sources <= 8'h00;
		// Low polarity captures on the return, one edge later
		@(posedge pclk);
		rd(PENDING_ONE_OFS, 32'h00010002, "hw like sw");
		wr(CLEAR_ONE_OFS, 32'h2);
		$display("t_sw done");
	endtask
	task t_edge;
		wr(POLARITY_TWO_OFS, 32'h00000100);
		external_sources <= 12'h100;
		@(posedge pclk);
		external_sources <= 12'h000;
		rd(PENDING_TWO_OFS, 32'h0, "unarmed");
		wr(ARM_TWO_OFS, 32'h08000100);
		external_sources <= 12'h100;
		@(posedge pclk);
		external_sources <= 12'h000;
		rd(PENDING_TWO_OFS, 32'h00000100, "rising");
		rd(PENDING_ONE_OFS, 32'h0, "summary clear");
		// Held high: a falling-sense source must ignore the rise
		group_c_lines <= 12'h800;
		rd(PENDING_TWO_OFS, 32'h00000100, "no rise");
		group_c_lines <= 12'h000;
		@(posedge pclk);
		rd(PENDING_TWO_OFS, 32'h08000100, "falling");
		n = irq_seen;
		wr(ENABLE_TWO_OFS, 32'h00000100);
		irq_is(1'b1, "edge irq");
		wr(CLEAR_TWO_OFS, 32'h00000200);
		rd(PENDING_TWO_OFS, 32'h08000100, "zero bits kept");
		wr(CLEAR_TWO_OFS, 32'h00000100);
		rd(PENDING_TWO_OFS, 32'h08000000, "bit cleared");
		irq_is(1'b0, "irq drop");
		chk(irq_seen === n + 1, "host count");
		$display("t_edge done");
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		begin : scen
			t_reset();
			t_map();
			t_level();
			t_sw();
			t_edge();
		end
		summarize();
	end
endmodule
